// ==== hdl/tag_alarm_gen.sv ====
// t1 transmit alarm insertion (rai and ais) with axi4-lite registers
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - format 00 sends no rai
// - sf/n format 01 clears ds0 bit 2
// - t1_data_mode_framing formats 01/11 clear y-bit
// - esf 01 sends 255 ff00 patterns
// - bit 6 trigger governs esf rai length
// - short trigger still yields 255 patterns
// - long trigger keeps rai until cleared
// - new trigger pulse restarts pattern count
// - one second idle between esf rai
// - sf format 11 sets fs frame 12
// - n format 11 same as 01
// - esf 11 sends 255 ffff patterns
// - ais select bits 3:2, reset 00
// - ais 00/10 normal traffic
// - ais 01 unframed all ones
// - ais 11 framed all ones
// - rai format bits 5:4, reset 00
module tag_alarm_gen #(
  parameter int IDLE_CNT = tag_pkg::IDLE_BITS  // idle length in data-link bits
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // inbound stream from the framer
  input  wire tag_pkg::tag_bit_t in_bit,
  input  wire logic              in_valid,
  output logic                   in_ready,
  // outbound stream to the line
  output tag_pkg::tag_bit_t      out_bit,
  output logic                   out_valid,
  input  wire logic              out_ready
);

  // ---------------- registers ----------------
  logic [7:0]       agc_r;       // alarm_generation_control
  tag_pkg::tag_frm_t frm_r;      // framing mode
  logic [1:0]       rai_sel;     // rai_format_sel
  logic [1:0]       ais_sel;     // tx_ais_pattern_sel
  logic             trig;        // rai_duration_trigger

  assign rai_sel = agc_r[tag_pkg::RAI_SEL_LSB +: 2];
  assign ais_sel = agc_r[tag_pkg::AIS_SEL_LSB +: 2];
  assign trig    = agc_r[tag_pkg::TRIG_BIT];

  // ---------------- axi write path ----------------
  logic       aw_hold_r;   // address taken, waiting for data
  logic       w_hold_r;    // data taken, waiting for address
  logic [7:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic       w_strb_r;
  logic       wr_go;       // both halves present this cycle
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_strb;

  // accept each half in either order; one write in flight at a time
  assign wr_addr = aw_hold_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_hold_r ? w_data_r : s_axi_wdata[7:0];
  assign wr_strb = w_hold_r ? w_strb_r : s_axi_wstrb[0];
  assign wr_go   = (aw_hold_r || (s_axi_awvalid && s_axi_awready))
                && (w_hold_r || (s_axi_wvalid && s_axi_wready));

  // ready only while that half is not already held and no response pends
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !s_axi_bvalid && !wr_go && !aw_hold_r
                    && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !s_axi_bvalid && !wr_go && !w_hold_r
                    && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // hold whichever half arrived first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 8'h00;
      w_strb_r  <= 1'b0;
    end
    else if (wr_go)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
      end
    end
  end

  // write response; unmapped address answers slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_addr == tag_pkg::ADDR_ALARM_GEN ||
                       wr_addr == tag_pkg::ADDR_FRAMING ||
                       wr_addr == tag_pkg::ADDR_STATUS) ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register storage; only byte lane 0 carries data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      agc_r <= tag_pkg::ALARM_GEN_RST;
      frm_r <= tag_pkg::tag_frm_t'(tag_pkg::FRAMING_RST);
    end
    else if (wr_go && wr_strb)
    begin
      if (wr_addr == tag_pkg::ADDR_ALARM_GEN)
        agc_r <= {1'b0, wr_data[6:0]};                // bit 7 unused
      else if (wr_addr == tag_pkg::ADDR_FRAMING)
        frm_r <= tag_pkg::tag_frm_t'(wr_data[1:0]);
    end
  end

  // ---------------- esf rai engine ----------------
  typedef enum logic [2:0] {
    TAG_ST_IDLE = 3'b001,  // no rai, ready to start
    TAG_ST_SEND = 3'b010,  // sending rai patterns
    TAG_ST_HOLD = 3'b100   // mandatory quiet gap
  } tag_st_t;

  tag_st_t     st_r;
  logic [7:0]  pat_cnt_r;     // index of the pattern under way in this burst; stops at RAI_PATS - 1
  logic [3:0]  pat_bit_r;     // bit within the 16-bit pattern
  logic [12:0] idle_cnt_r;    // quiet-gap counter in dl bits
  logic        trig_d_r;      // trigger delayed, for edge detect
  logic        trig_rise;
  logic        esf_rai_en;
  logic        dl_step;       // a data-link bit is accepted from the input this cycle
  logic        pat_last;      // last bit of a pattern

  assign trig_rise  = trig && !trig_d_r;
  assign esf_rai_en = (frm_r == tag_pkg::TAG_FRM_ESF) && (rai_sel != tag_pkg::RAI_OFF);
  assign dl_step    = in_valid && in_ready && in_bit.pos.dl_slot;
  assign pat_last   = (pat_bit_r == 4'(tag_pkg::PAT_BITS - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trig_d_r <= 1'b0;
    else
      trig_d_r <= trig;
  end

  // burst state: a burst ends on a pattern boundary, or at once when esf rai is disabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r       <= TAG_ST_IDLE;
      pat_cnt_r  <= 8'h00;
      pat_bit_r  <= 4'h0;
      idle_cnt_r <= 13'h0000;
    end
    else
    begin
      case (st_r)
        TAG_ST_IDLE:
        begin
          // start on the trigger only; gap already served
          if (esf_rai_en && trig)
          begin
            st_r      <= TAG_ST_SEND;
            pat_cnt_r <= 8'h00;
            pat_bit_r <= 4'h0;
          end
        end
        TAG_ST_SEND:
        begin
          if (!esf_rai_en)
          begin
            st_r       <= TAG_ST_HOLD;
            idle_cnt_r <= 13'h0000;
          end
          else if (trig_rise)
          begin
            pat_cnt_r <= 8'h00;
            if (dl_step)
              pat_bit_r <= pat_bit_r + 4'h1;
          end
          else if (dl_step)
          begin
            pat_bit_r <= pat_bit_r + 4'h1;
            if (pat_last)
            begin
              if (pat_cnt_r == 8'(tag_pkg::RAI_PATS - 1) && !trig)
              begin
                st_r       <= TAG_ST_HOLD;
                idle_cnt_r <= 13'h0000;
              end
              else if (pat_cnt_r != 8'(tag_pkg::RAI_PATS - 1))
                pat_cnt_r <= pat_cnt_r + 8'h01;
            end
          end
        end
        TAG_ST_HOLD:
        begin
          // quiet gap timed in data-link bits, ~one second
          if (idle_cnt_r >= 13'(IDLE_CNT - 1) && dl_step)
            st_r <= TAG_ST_IDLE;
          else if (dl_step)
            idle_cnt_r <= idle_cnt_r + 13'h0001;
        end
        default:
          st_r <= TAG_ST_IDLE;
      endcase
    end
  end

  // ---------------- bit insertion ----------------
  logic     ais_on;
  logic     rai_on;
  logic     dl_pat_bit;
  logic     mod_data;
  tag_pkg::tag_bit_t mod_bit;

  assign ais_on = ais_sel[0];
  assign rai_on = (rai_sel != tag_pkg::RAI_OFF) && (rai_sel != 2'h2);
  assign dl_pat_bit = (rai_sel == tag_pkg::RAI_J1)
                    ? tag_pkg::DL_PAT_J1[4'hf - pat_bit_r]
                    : tag_pkg::DL_PAT_STD[4'hf - pat_bit_r];

  // ais first, then rai per framing mode
  always_comb
  begin
    mod_data = in_bit.data;
    if (ais_on)
    begin
      if (ais_sel == tag_pkg::AIS_UNFR)
        mod_data = 1'b1;
      else if (!in_bit.pos.fbit && !in_bit.pos.dl_slot)
        mod_data = 1'b1;
    end
    else if (rai_on)
    begin
      case (frm_r)
        tag_pkg::TAG_FRM_SF:
        begin
          if (rai_sel == tag_pkg::RAI_J1)
          begin
            if (in_bit.pos.fbit && in_bit.pos.frame == 4'hb)
              mod_data = 1'b1;
          end
          else if (!in_bit.pos.fbit && in_bit.pos.bit_idx == 3'h1)
            mod_data = 1'b0;
        end
        tag_pkg::TAG_FRM_N:
        begin
          if (!in_bit.pos.fbit && in_bit.pos.bit_idx == 3'h1)
            mod_data = 1'b0;
        end
        tag_pkg::TAG_FRM_T1_DATA_MODE_FRAMING:
        begin
          if (in_bit.pos.sync_byte && in_bit.pos.bit_idx == 3'h5)
            mod_data = 1'b0;
        end
        tag_pkg::TAG_FRM_ESF:
        begin
          if (st_r == TAG_ST_SEND && in_bit.pos.dl_slot)
            mod_data = dl_pat_bit;
        end
        default:
          mod_data = in_bit.data;
      endcase
    end
  end

  always_comb
  begin
    mod_bit      = in_bit;
    mod_bit.data = mod_data;
  end

  // ---------------- two-entry output buffer ----------------
  tag_pkg::tag_bit_t buf_r [2];
  logic [1:0]        cnt_r;     // entries held
  logic              rd_r;      // read index
  logic              push;
  logic              pop;

  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;

  // stall the source when both entries are full
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= 2'h0;
      rd_r  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      if (pop)
        rd_r <= ~rd_r;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
    end
    else if (push)
      buf_r[rd_r ^ cnt_r[0]] <= mod_bit;
  end

  // registered handshake outputs derived from next occupancy
  logic [1:0] cnt_nxt;
  logic       rd_nxt;
  assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  assign rd_nxt  = pop ? ~rd_r : rd_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
      out_bit   <= '0;
    end
    else
    begin
      in_ready  <= (cnt_nxt != 2'h2);
      out_valid <= (cnt_nxt != 2'h0);
      out_bit   <= (cnt_r == 2'h0 || (pop && cnt_r == 2'h1)) ? mod_bit
                 : (pop ? buf_r[~rd_r] : buf_r[rd_r]);
    end
  end

  // ---------------- axi read path ----------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'h0;
      case (s_axi_araddr)
        tag_pkg::ADDR_ALARM_GEN: s_axi_rdata <= {24'h000000, agc_r};
        tag_pkg::ADDR_FRAMING:   s_axi_rdata <= {30'h0, frm_r};
        tag_pkg::ADDR_STATUS:    s_axi_rdata <= {21'h0, pat_cnt_r, st_r};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;                         // unmapped
        end
      endcase
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end

endmodule
`default_nettype wire

// ==== hdl/tag_pkg.sv ====
// package for the t1 transmit alarm generator: register map, fields, timing
package tag_pkg;
  // register byte addresses (two registers plus one status word)
  localparam logic [7:0] ADDR_ALARM_GEN   = 8'h08;  // alarm_generation_control
  localparam logic [7:0] ADDR_FRAMING     = 8'h00;  // framing mode select
  localparam logic [7:0] ADDR_STATUS      = 8'h04;  // rai engine status
  // alarm_generation_control field positions
  localparam int TRIG_BIT     = 6;  // rai_duration_trigger
  localparam int RAI_SEL_LSB  = 4;  // rai_format_sel [5:4]
  localparam int AIS_SEL_LSB  = 2;  // tx_ais_pattern_sel [3:2]
  localparam logic [7:0] ALARM_GEN_RST = 8'h00;  // reset value
  localparam logic [1:0] FRAMING_RST   = 2'h0;   // reset framing: sf
  // format codes
  localparam logic [1:0] RAI_OFF    = 2'h0;
  localparam logic [1:0] RAI_STD    = 2'h1;
  localparam logic [1:0] RAI_J1     = 2'h3;
  localparam logic [1:0] AIS_UNFR   = 2'h1;
  localparam logic [1:0] AIS_FRMD   = 2'h3;
  // data-link patterns and counts
  localparam logic [15:0] DL_PAT_STD = 16'hff00;
  localparam logic [15:0] DL_PAT_J1  = 16'hffff;
  localparam int          RAI_PATS   = 255;       // patterns per burst
  localparam int          PAT_BITS   = 16;
  // one second idle at 4 kbit/s data link = 4000 dl bits
  localparam int          IDLE_MS    = 1000;
  localparam int          DL_RATE    = 4000;      // data-link bits per second
  localparam int          IDLE_BITS  = DL_RATE * IDLE_MS / 1000;
  // framing modes
  typedef enum logic [1:0] {
    TAG_FRM_SF   = 2'h0,
    TAG_FRM_ESF  = 2'h1,
    TAG_FRM_N    = 2'h2,
    TAG_FRM_T1_DATA_MODE_FRAMING = 2'h3
  } tag_frm_t;
  // position of the current outbound bit within the t1 stream
  typedef struct packed {
    logic       fbit;      // framing bit slot
    logic [3:0] frame;     // frame 1..12 within superframe (sf) less one
    logic       dl_slot;   // esf data-link bit slot
    logic [2:0] bit_idx;   // bit within ds0, 0 = msb
    logic       sync_byte; // t1_data_mode_framing sync byte slot
  } tag_pos_t;
  // one outbound bit with its position
  typedef struct packed {
    logic     data;
    tag_pos_t pos;
  } tag_bit_t;
endpackage

// ==== sim/tag_alarm_gen_checker.sv ====
// port checker for the t1 transmit alarm generator
`timescale 1ns/100ps
`default_nettype none
module tag_alarm_gen_checker #(
  parameter int IDLE_CNT = 8  // data-link bits of the gap
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [7:0]        s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire tag_pkg::tag_bit_t out_bit,
  input wire logic              out_valid,
  input wire logic              out_ready
);
  logic [7:0] aw_r;   // address of the write under way
  logic [7:0] wd_r;   // data of the write under way
  logic [7:0] agc_r;  // shadow of alarm_generation_control
  logic [1:0] frm_r;  // shadow of the framing mode
  logic [2:0] st_r;   // cycles since a write, saturating
  logic       ok;     // settled: old bits have left
  assign ok = st_r == 3'h7;
  // shadow follows completed writes only, so a refused one leaves it
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      aw_r  <= 8'h00;
      wd_r  <= 8'h00;
      agc_r <= 8'h00;
      frm_r <= 2'h0;
      st_r  <= 3'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        wd_r <= s_axi_wdata[7:0];
      if (s_axi_bvalid && s_axi_bready)
      begin
        st_r <= 3'h0;
        if (aw_r == tag_pkg::ADDR_ALARM_GEN)
          agc_r <= wd_r;
        if (aw_r == tag_pkg::ADDR_FRAMING)
          frm_r <= wd_r[1:0];
      end
      else if (!ok)
        st_r <= st_r + 3'h1;
    end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  out_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_bit)) else $error("stalled bit changed");
  ais_unframed_a: assert property (
    ok && agc_r[3:2] == 2'h1 && out_valid |-> out_bit.data)
    else $error("unframed ais bit not one");
  ais_framed_a: assert property (
    ok && agc_r[3:2] == 2'h3 && out_valid && !out_bit.pos.fbit |-> out_bit.data)
    else $error("framed ais payload not one");
  rai_bit2_a: assert property (
    ok && !agc_r[2] && agc_r[4] && (frm_r == 2'h0 && !agc_r[5] || frm_r == 2'h2)
    && out_valid && !out_bit.pos.fbit && out_bit.pos.bit_idx == 3'h1 |-> !out_bit.data)
    else $error("ds0 bit 2 not cleared");
  rai_ybit_a: assert property (
    ok && !agc_r[2] && agc_r[4] && frm_r == 2'h3 && out_valid
    && out_bit.pos.sync_byte && out_bit.pos.bit_idx == 3'h5 |-> !out_bit.data)
    else $error("sync byte y bit not cleared");
endmodule
bind tag_alarm_gen tag_alarm_gen_checker #(.IDLE_CNT(IDLE_CNT)) u_chk (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .out_bit,
  .out_valid, .out_ready);
`default_nettype wire

// ==== sim/tag_line_sink.sv ====
// remote terminal stand-in that paces the outbound stream
`timescale 1ns/100ps
`default_nettype none
module tag_line_sink (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic hold,      // stall on command
  output logic      out_ready
);
  logic [3:0] cnt_r;  // pacing pattern
  // ready three cycles in four so the buffer sees back-pressure
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      cnt_r     <= 4'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      cnt_r     <= cnt_r + 4'h1;
      out_ready <= !hold && cnt_r[1:0] != 2'h3;
    end
endmodule
`default_nettype wire

// ==== sim/tb_tag_alarm_gen.sv ====
// self-checking bench for the t1 transmit alarm generator
`timescale 1ns/100ps
`default_nettype none
module tb_tag_alarm_gen;
  logic              aclk, aresetn, hold;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, in_valid, in_ready;
  logic              out_valid, out_ready;
  tag_pkg::tag_bit_t in_bit, out_bit, b, e;
  tag_pkg::tag_bit_t q[$];  // expected outbound bits, oldest first
  logic [31:0]       seed;  // lfsr state
  logic [15:0]       pat;   // data-link pattern in use
  int                errors, samples_checked, cyc, n;
  tag_alarm_gen #(.IDLE_CNT(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .in_bit, .in_valid, .in_ready, .out_bit, .out_valid, .out_ready);
  tag_line_sink u_sink (.aclk, .aresetn, .hold, .out_ready);
  // clock at 25 MHz
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] nxt(logic [31:0] r);
    return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction
  // random inbound bit with a legal position for framing f
  function automatic tag_pkg::tag_bit_t rnd(logic [31:0] r, logic [1:0] f);
    tag_pkg::tag_bit_t t;
    t.data          = r[0];
    t.pos.fbit      = r[1];
    t.pos.frame     = r[5:2] % 4'hc;
    t.pos.dl_slot   = r[1] & r[6] & (f == 2'h1);
    t.pos.bit_idx   = r[9:7];
    t.pos.sync_byte = !r[1] & r[10] & (f == 2'h3);
    return t;
  endfunction
  // expected bit under framing f, rai format y, ais select s
  function automatic tag_pkg::tag_bit_t xp(tag_pkg::tag_bit_t t, logic [1:0] f, y, s);
    tag_pkg::tag_bit_t o;
    o = t;
    if (s == 2'h1)
      o.data = 1'b1;
    else if (s == 2'h3)
      o.data = t.data | !t.pos.fbit;
    else if (f == 2'h0 && y == 2'h3 && t.pos.fbit && t.pos.frame == 4'hb)
      o.data = 1'b1;
    else if (!t.pos.fbit && t.pos.bit_idx == 3'h1 && y[0] && (f == 2'h0 && !y[1] || f == 2'h2))
      o.data = 1'b0;
    else if (f == 2'h3 && y[0] && t.pos.sync_byte && t.pos.bit_idx == 3'h5)
      o.data = 1'b0;
    return o;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  // present one bit from the current edge; returns at its handshake
  task automatic send(input tag_pkg::tag_bit_t t, input tag_pkg::tag_bit_t x);
    in_bit   <= t;
    in_valid <= 1'b1;
    do @(posedge aclk); while (!in_ready);
    q.push_back(x);
  endtask
  task automatic drain;
    in_valid <= 1'b0;
    while (q.size() != 0) @(posedge aclk);
  endtask
  // compare each delivered bit with the oldest expectation
  always @(posedge aclk)
    if (aresetn && out_valid && out_ready)
      chk(32'(out_bit), q.size() != 0 ? 32'(q.pop_front()) : 'x);
  // hang guard, well above the expected run length
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      summarize;
    end
  end
  initial
  begin
    {aresetn, hold, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, in_valid, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, in_bit} = '0;
    s_axi_wstrb = 4'hf;
    seed = 32'hc07c4eb8;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(tag_pkg::ADDR_ALARM_GEN, 32'h0, 2'h0);
    rd(tag_pkg::ADDR_FRAMING, 32'h0, 2'h0);
    wr(tag_pkg::ADDR_ALARM_GEN, 8'h3c, 2'h0);
    rd(tag_pkg::ADDR_ALARM_GEN, 32'h3c, 2'h0);
    wr(8'h0c, 8'h01, 2'h2);
    rd(8'h0c, 32'h0, 2'h2);
    $display("test registers done");
    // every framing, rai format and ais select
    for (int f = 0; f < 4; f++)
      for (int y = 0; y < 4; y++)
        for (int s = 0; s < 4; s++)
        begin
          wr(tag_pkg::ADDR_FRAMING, 8'(f), 2'h0);
          wr(tag_pkg::ADDR_ALARM_GEN, {2'h0, 2'(y), 2'(s), 2'h0}, 2'h0);
          repeat (32)
          begin
            seed = nxt(seed);
            b = rnd(seed, 2'(f));
            send(b, xp(b, 2'(f), 2'(y), 2'(s)));
          end
          drain;
        end
    $display("test modes done");
    // far side stalls: buffer must refuse, then lose nothing
    wr(tag_pkg::ADDR_ALARM_GEN, 8'h00, 2'h0);
    hold <= 1'b1;
    b = rnd(seed, 2'h3);
    in_bit   <= b;
    in_valid <= 1'b1;
    repeat (8)
    begin
      @(posedge aclk);
      if (in_ready)
      begin
        q.push_back(b);
        seed = nxt(seed);
        b = rnd(seed, 2'h3);
        in_bit <= b;
      end
    end
    chk(32'(in_ready), 32'h0);
    hold <= 1'b0;
    drain;
    $display("test buffer done");
    // esf data-link rai: short pulse with a retrigger and a start refused in the gap,
    // short pulse in the other format, then a trigger held past 255 patterns
    wr(tag_pkg::ADDR_FRAMING, 8'h01, 2'h0);
    for (int k = 0; k < 3; k++)
    begin
      wr(tag_pkg::ADDR_ALARM_GEN, (k == 1) ? 8'h70 : 8'h50, 2'h0);
      if (k != 2)
        wr(tag_pkg::ADDR_ALARM_GEN, (k == 1) ? 8'h30 : 8'h10, 2'h0);
      pat = (k == 1) ? tag_pkg::DL_PAT_J1 : tag_pkg::DL_PAT_STD;
      n = tag_pkg::PAT_BITS * (tag_pkg::RAI_PATS + ((k == 1) ? 0 : 1 + k / 2));
      for (int i = 0; i < n + 32; i++)
      begin
        if (k == 0 && i == tag_pkg::PAT_BITS)
        begin
          drain;  // fresh pulse after one pattern: 255 more follow
          wr(tag_pkg::ADDR_ALARM_GEN, 8'h50, 2'h0);
          wr(tag_pkg::ADDR_ALARM_GEN, 8'h10, 2'h0);
        end
        if (k == 2 && i == n - tag_pkg::PAT_BITS)
        begin
          drain;  // trigger dropped between patterns: the next pattern is the last
          wr(tag_pkg::ADDR_ALARM_GEN, 8'h10, 2'h0);
        end
        if (k == 0 && i == n)
        begin
          drain;  // a trigger inside the quiet gap must not start a burst
          wr(tag_pkg::ADDR_ALARM_GEN, 8'h50, 2'h0);
          rd(tag_pkg::ADDR_STATUS, 32'({8'(tag_pkg::RAI_PATS - 1), 3'h4}), 2'h0);
          wr(tag_pkg::ADDR_ALARM_GEN, 8'h10, 2'h0);
        end
        seed = nxt(seed);
        b = '0;
        b.data = seed[0];
        b.pos.fbit = 1'b1;
        b.pos.dl_slot = 1'b1;
        e = b;
        if (i < n)
          e.data = pat[15 - i % 16];
        send(b, e);
      end
      drain;
    end
    $display("test esf rai done");
    summarize;
  end
endmodule
`default_nettype wire
